// file: duobinary_coder_defines.vh
// constants for the duobinary pulse coder: symbol encodings, codes, levels
`ifndef DUOBINARY_CODER_DEFINES_VH
`define DUOBINARY_CODER_DEFINES_VH

// mac symbol encodings on i_mac_sym
`define SYM_ZERO 3'h0
`define SYM_ONE 3'h1
`define SYM_NON_DATA 3'h2
`define SYM_PAD_IDLE 3'h3
`define SYM_SILENCE 3'h4

// phy codes, value equals the numeric code {0} {2} {4}
`define CODE_LOW 3'h0
`define CODE_MID 3'h2
`define CODE_TOP 3'h4

// pulse levels, three-bit two's complement
`define LVL_NEG 3'h6
`define LVL_ZERO 3'h0
`define LVL_POS 3'h2

// scrambler register length and preset value
`define SCR_LEN 7
`define SCR_PRESET 7'h7f

// index of the last symbol in a phy octet
`define OCTET_LAST 3'h7

// frame delimiter non_data pattern of the seven symbols before the last data
`define DELIM_PATTERN 7'h6c

// data slots among the same seven symbols, which must hold zero or one
`define DELIM_DATA 7'h13

`endif

// file: data_scrambler.v
// self-synchronising data scrambler, division by 1 + x^-6 + x^-7
`timescale 1ns/1ns
`include "duobinary_coder_defines.vh"

module data_scrambler (
    input wire i_sys_clk,     // symbol-rate clock
    input wire i_reset,       // synchronous, active high
    input wire i_step,        // advance on a data symbol
    input wire i_preset,      // reload all ones on a non_data symbol
    input wire i_data_bit,    // unscrambled data bit
    output wire o_scr_bit     // scrambled (quotient) bit
);

    reg [`SCR_LEN-1:0] state_reg;

    // quotient bit: input plus the feedback from delays six and seven
    assign o_scr_bit = i_data_bit ^ state_reg[5] ^ state_reg[6];

    // only data steps shift the register; non_data presets it, everything else holds it
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_reg <= `SCR_PRESET;
        end else if (i_preset) begin
            state_reg <= `SCR_PRESET;
        end else if (i_step) begin
            state_reg <= {state_reg[5:0], o_scr_bit};
        end
    end

endmodule

// file: duobinary_pulse_coder.v
// transmit symbol coder: scrambler, octet substitution and duobinary pulse selection
// What this block does
// - octet substitution happens after scrambling and never touches scrambler state
// - only zero and one are scrambled; others bypass without stepping the scrambler
// - exactly one pulse of -2, 0 or +2 per phy symbol
// - the last two emitted pulse levels are kept as history
// - low code: negate a nonzero prior pulse, else emit 0
// - top code repeats a nonzero prior pulse
// - sampled amplitude is 0 for low, half for mid and for top after a zero prior, full for other top codes
// - codes other than top after a zero prior are recoverable by rectified amplitude alone, no phase needed
// - data is scrambled by dividing by taps at delays six and seven
// - non_data presets scrambler to all ones and is coded as mid
// - scrambled zero maps to low code, scrambled one to top code
// - repeated uniform data octet gets its last three codes swapped for opposite, mid, mid
`timescale 1ns/1ns
`include "duobinary_coder_defines.vh"

module duobinary_pulse_coder (
    input wire i_sys_clk,          // symbol-rate clock, 25 MHz
    input wire i_reset,            // synchronous, active high
    input wire i_sym_en,           // one-cycle strobe, one mac symbol per strobe
    input wire [2:0] i_mac_sym,    // mac symbol taken on i_sym_en
    output reg [2:0] o_pulse_level, // pulse level, two's complement -2/0/+2
    output reg [2:0] o_phy_code,   // phy code carried by that pulse
    output reg o_pulse_valid       // one-cycle strobe with each new pulse
);

    // input classification
    wire is_data = (i_mac_sym == `SYM_ZERO) || (i_mac_sym == `SYM_ONE);
    wire is_nd = (i_mac_sym == `SYM_NON_DATA);
    wire scr_bit;

    data_scrambler u_scr (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_step(i_sym_en & is_data),
        .i_preset(i_sym_en & is_nd),
        .i_data_bit(i_mac_sym == `SYM_ONE),
        .o_scr_bit(scr_bit)
    );

    // pad_idle alternates top then low, restarting each new run
    reg pad_phase_reg;
    reg [2:0] prev_sym_reg;
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            pad_phase_reg <= 1'b0;
            prev_sym_reg <= `SYM_SILENCE;
        end else if (i_sym_en) begin
            prev_sym_reg <= i_mac_sym;
            if (i_mac_sym == `SYM_PAD_IDLE) begin
                pad_phase_reg <= ~pad_phase_reg;
            end else begin
                pad_phase_reg <= 1'b0;
            end
        end
    end

    // map the symbol to its phy code; scrambled bits only for data
    reg [2:0] in_code;
    always @* begin
        case (i_mac_sym)
            `SYM_ZERO, `SYM_ONE: in_code = scr_bit ? `CODE_TOP : `CODE_LOW;
            `SYM_NON_DATA: in_code = `CODE_MID;
            `SYM_PAD_IDLE: in_code = pad_phase_reg ? `CODE_LOW : `CODE_TOP;
            default: in_code = `CODE_LOW;
        endcase
    end

    // silence: first and last of a run are mid, the rest low; the last one
    // is only known when the next symbol arrives, so it is patched in the
    // delay line below
    wire sil_first = (i_mac_sym == `SYM_SILENCE) && (prev_sym_reg != `SYM_SILENCE);
    wire sil_last = (i_mac_sym != `SYM_SILENCE) && (prev_sym_reg == `SYM_SILENCE);
    wire [2:0] code_in = sil_first ? `CODE_MID : in_code;

    // octet alignment starts after the eight-symbol frame delimiter
    reg [6:0] nd_hist_reg;
    reg [6:0] dat_hist_reg;
    reg aligned_reg;
    reg [2:0] octet_pos_reg;
    reg octet_same_reg;
    reg [2:0] octet_code_reg;
    reg prev_uniform_reg;
    reg [2:0] prev_uniform_code_reg;
    // the non_data pattern alone is not enough: a pad, silence or unknown
    // symbol in a data slot would otherwise start a false octet alignment
    wire delim_end = is_data && (nd_hist_reg == `DELIM_PATTERN)
        && (dat_hist_reg == `DELIM_DATA);
    wire pos_first = (octet_pos_reg == 3'h0);
    wire same_now = is_data && (pos_first || (octet_same_reg && code_in == octet_code_reg));
    wire octet_end = aligned_reg && (octet_pos_reg == `OCTET_LAST);
    wire do_subst = octet_end && same_now && prev_uniform_reg
        && (prev_uniform_code_reg == code_in);

    // octet tracking runs on the post-scrambler codes, never back into the scrambler
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            nd_hist_reg <= 7'h00;
            dat_hist_reg <= 7'h00;
            aligned_reg <= 1'b0;
            octet_pos_reg <= 3'h0;
            octet_same_reg <= 1'b0;
            octet_code_reg <= `CODE_LOW;
            prev_uniform_reg <= 1'b0;
            prev_uniform_code_reg <= `CODE_LOW;
        end else if (i_sym_en) begin
            nd_hist_reg <= {nd_hist_reg[5:0], is_nd};
            dat_hist_reg <= {dat_hist_reg[5:0], is_data};
            octet_same_reg <= same_now;
            if (pos_first) begin
                octet_code_reg <= code_in;
            end
            if (delim_end) begin
                aligned_reg <= 1'b1;
                octet_pos_reg <= 3'h0;
                prev_uniform_reg <= 1'b0;
            end else if (!is_data) begin
                // any non-data symbol ends the data stream and its alignment
                aligned_reg <= 1'b0;
                octet_pos_reg <= 3'h0;
                prev_uniform_reg <= 1'b0;
            end else if (aligned_reg) begin
                octet_pos_reg <= octet_pos_reg + 3'h1;
                if (octet_end) begin
                    // an altered octet is no longer uniform as transmitted
                    prev_uniform_reg <= same_now && !do_subst;
                    prev_uniform_code_reg <= code_in;
                end
            end
        end
    end

    // three-symbol delay line so the whole octet is seen before its last
    // three codes leave; costs fixed latency, buys the substitution
    reg [2:0] dly0_reg;
    reg [2:0] dly1_reg;
    reg [2:0] dly2_reg;
    reg [2:0] sub_opp;
    // opposite data code for the first of the three replaced slots
    always @* begin
        sub_opp = (code_in == `CODE_TOP) ? `CODE_LOW : `CODE_TOP;
    end

    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            dly0_reg <= `CODE_LOW;
            dly1_reg <= `CODE_LOW;
            dly2_reg <= `CODE_LOW;
        end else if (i_sym_en) begin
            if (do_subst) begin
                dly2_reg <= sub_opp;
                dly1_reg <= `CODE_MID;
                dly0_reg <= `CODE_MID;
            end else begin
                dly2_reg <= dly1_reg;
                dly1_reg <= dly0_reg;
                dly0_reg <= code_in;
                if (sil_last) begin
                    // the previous silence was the last of its run
                    dly1_reg <= `CODE_MID;
                end
            end
        end
    end

    // pulse history: prior and second-prior emitted levels
    // a zero prior carries no polarity, so the sign picked there is free; the
    // receiver rectifies, so a fixed +2 for top (mid repeats a nonzero second prior, else +2) costs nothing and keeps the logic small
    reg [2:0] prior_reg;
    reg [2:0] prior2_reg;
    reg [2:0] level_next;
    always @* begin
        level_next = `LVL_ZERO;
        case (dly2_reg)
            `CODE_LOW: begin
                // negation of +2/-2; a zero prior stays zero
                level_next = (prior_reg == `LVL_ZERO) ? `LVL_ZERO : (3'h0 - prior_reg);
            end
            `CODE_MID: begin
                if (prior_reg != `LVL_ZERO) begin
                    level_next = `LVL_ZERO;
                end else if (prior2_reg != `LVL_ZERO) begin
                    level_next = prior2_reg;
                end else begin
                    level_next = `LVL_POS;
                end
            end
            `CODE_TOP: begin
                // from a zero prior either polarity gives the same half amplitude
                level_next = (prior_reg == `LVL_ZERO) ? `LVL_POS : prior_reg;
            end
            default: level_next = `LVL_ZERO;
        endcase
    end

    // registered output; sum of adjacent duobinary pulses is 0, 2 or 4 in
    // magnitude, so rectified amplitude yields the code except for top after a zero prior
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            prior_reg <= `LVL_ZERO;
            prior2_reg <= `LVL_ZERO;
            o_pulse_level <= `LVL_ZERO;
            o_phy_code <= `CODE_LOW;
            o_pulse_valid <= 1'b0;
        end else begin
            o_pulse_valid <= i_sym_en;
            if (i_sym_en) begin
                prior2_reg <= prior_reg;
                prior_reg <= level_next;
                o_pulse_level <= level_next;
                o_phy_code <= dly2_reg;
            end
        end
    end
    // holds by construction of level_next above

endmodule

// file: duobinary_pulse_coder_chk.sv
// checker: strobe timing and pulse history rules of the duobinary coder
`timescale 1ns/1ns
module duobinary_pulse_coder_chk (
    input wire i_sys_clk, // clock
    input wire i_reset, // reset
    input wire i_sym_en, // symbol strobe
    input wire [2:0] o_pulse_level, // pulse level
    input wire [2:0] o_phy_code, // code of that pulse
    input wire o_pulse_valid // pulse strobe
);
    reg [2:0] p1_reg;
    reg [2:0] p2_reg;
    wire [3:0] sum;
    wire [3:0] mag;
    // prior and second prior pulse, cleared like the coder's history
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            p1_reg <= 3'h0;
            p2_reg <= 3'h0;
        end else if (o_pulse_valid) begin
            p1_reg <= o_pulse_level;
            p2_reg <= p1_reg;
        end
    end
    // duobinary pair sum, rectified: what the receiver samples
    assign sum = {o_pulse_level[2], o_pulse_level} + {p1_reg[2], p1_reg};
    assign mag = sum[3] ? -sum : sum;
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);
    sequence strobe_s;
        i_sym_en ##1 o_pulse_valid;
    endsequence
    valid_delay_a: assert property (i_sym_en |-> strobe_s)
        else $error("pulse strobe missing");
    valid_quiet_a: assert property (!i_sym_en |=> !o_pulse_valid)
        else $error("pulse strobe without symbol");
    level_hold_a: assert property (!i_sym_en |=> $stable(o_pulse_level))
        else $error("level moved between strobes");
    level_set_a: assert property (o_pulse_level inside {3'h6, 3'h0, 3'h2})
        else $error("illegal pulse level");
    low_code_a: assert property (o_pulse_valid && o_phy_code == 3'h0 |-> o_pulse_level == 3'h0 - p1_reg)
        else $error("low code pulse wrong");
    mid_first_a: assert property (o_pulse_valid && o_phy_code == 3'h2 && p1_reg != 3'h0
        |-> o_pulse_level == 3'h0)
        else $error("mid code after pulse not zero");
    mid_second_a: assert property (o_pulse_valid && o_phy_code == 3'h2 && p1_reg == 3'h0
        && p2_reg != 3'h0 |-> o_pulse_level == p2_reg)
        else $error("mid code after zero wrong");
    top_code_a: assert property (o_pulse_valid && o_phy_code == 3'h4 && p1_reg != 3'h0
        |-> o_pulse_level == p1_reg)
        else $error("top code pulse wrong");
    amp_match_a: assert property (o_pulse_valid && (p1_reg != 3'h0 || o_phy_code != 3'h4)
        |-> mag == {1'b0, o_phy_code})
        else $error("rectified amplitude off");
    reset_clear_a: assert property (disable iff (1'b0) i_reset
        |=> !o_pulse_valid && o_pulse_level == 3'h0)
        else $error("reset left pulse state");
endmodule
bind duobinary_pulse_coder duobinary_pulse_coder_chk chk (.i_sys_clk(i_sys_clk),
    .i_reset(i_reset), .i_sym_en(i_sym_en), .o_pulse_level(o_pulse_level),
    .o_phy_code(o_phy_code), .o_pulse_valid(o_pulse_valid));

// file: mac_symbol_source.sv
// partner model: mac sublayer entity handing symbols to the coder
`timescale 1ns/1ns
module mac_symbol_source (
    input wire i_sys_clk, // clock
    input wire i_slow, // leave random gaps
    output reg o_sym_en, // symbol strobe
    output reg [2:0] o_mac_sym // symbol
);
    reg [2:0] sym_q[$];
    integer seed = 35959;
    initial begin
        o_sym_en = 1'b0;
        o_mac_sym = 3'h4;
    end
    // idle cycles toggle the symbol so a stale value is never reused
    always @(negedge i_sys_clk) begin
        if (sym_q.size() > 0 && !(i_slow && $random(seed) % 3 == 0)) begin
            o_sym_en <= 1'b1;
            o_mac_sym <= sym_q.pop_front();
        end else begin
            o_sym_en <= 1'b0;
            o_mac_sym <= ~o_mac_sym;
        end
    end
endmodule

// file: test_duobinary_pulse_coder.sv
// self-checking bench: phy code stream against a behavioural coder model
`timescale 1ns/1ns
`include "duobinary_coder_defines.vh"
module test_duobinary_pulse_coder;
    reg i_sys_clk = 1'b0;
    reg i_reset = 1'b1;
    reg slow = 1'b0;
    wire sym_en, valid;
    wire [2:0] sym, level, code;
    reg [2:0] exp_q[$];
    reg [6:0] scr;
    reg [7:0] nd8, dat8;
    reg [2:0] prev;
    reg [2:0] h1, h2, lv, ec;
    reg [31:0] r;
    reg pad_ph, align;
    integer idx, uni, prev_uni, k, fails = 0, checked = 0, seed = 35959;
    mac_symbol_source src (.i_sys_clk(i_sys_clk), .i_slow(slow), .o_sym_en(sym_en),
        .o_mac_sym(sym));
    duobinary_pulse_coder uut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_sym_en(sym_en),
        .i_mac_sym(sym), .o_pulse_level(level), .o_phy_code(code), .o_pulse_valid(valid));
    initial forever #20 i_sys_clk = ~i_sys_clk;
    task check_code(input [7:0] got, input [7:0] want_v);
        begin
            checked = checked + 1;
            if (got !== want_v) begin
                fails = fails + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, want_v);
            end
        end
    endtask
    task check_level(input [2:0] got, input [2:0] want_v);
        begin
            checked = checked + 1;
            if (got !== want_v) begin
                fails = fails + 1;
                $display("unexpected at %0t: level %h want %h", $time, got, want_v);
            end
        end
    endtask
    // expected pulse from the expected code and the two previous expected pulses
    function [2:0] pulse_for(input [2:0] c, input [2:0] a, input [2:0] b);
        begin
            if (c == `CODE_LOW) begin
                pulse_for = 3'h0 - a;
            end else if (c == `CODE_TOP) begin
                pulse_for = (a == `LVL_ZERO) ? `LVL_POS : a;
            end else if (a != `LVL_ZERO) begin
                pulse_for = `LVL_ZERO;
            end else begin
                pulse_for = (b == `LVL_ZERO) ? `LVL_POS : b;
            end
        end
    endfunction
    // reset leaves three low codes in the delay line and a silence behind
    task model_reset;
        begin
            exp_q = {3'h0, 3'h0, 3'h0};
            scr = `SCR_PRESET;
            prev = `SYM_SILENCE;
            nd8 = 8'h00;
            dat8 = 8'h00;
            align = 1'b0;
            h1 = `LVL_ZERO;
            h2 = `LVL_ZERO;
        end
    endtask
    // queue one symbol and work out its code, patching history as needed
    task add(input [2:0] s);
        integer j;
        reg [2:0] c;
        begin
            c = `CODE_LOW;
            if (s != `SYM_SILENCE && prev == `SYM_SILENCE) exp_q[$] = `CODE_MID;
            if (s > 3'h1) align = 1'b0;
            nd8 = {nd8[6:0], s == `SYM_NON_DATA};
            dat8 = {dat8[6:0], s < 3'h2};
            case (s)
            `SYM_ZERO, `SYM_ONE: begin
                c = {s[0] ^ scr[5] ^ scr[6], 2'b00};
                scr = {scr[5:0], c[2]};
            end
            `SYM_NON_DATA: begin
                scr = `SCR_PRESET;
                c = `CODE_MID;
            end
            `SYM_PAD_IDLE: begin
                pad_ph = (prev == `SYM_PAD_IDLE) ? ~pad_ph : 1'b0;
                c = pad_ph ? `CODE_LOW : `CODE_TOP;
            end
            `SYM_SILENCE: c = (prev == `SYM_SILENCE) ? `CODE_LOW : `CODE_MID;
            endcase
            exp_q.push_back(c);
            if (align) begin
                idx = idx + 1;
                if (idx == 8) begin
                    idx = 0;
                    uni = 0;
                    for (j = 1; j <= 8; j = j + 1) uni = uni | (exp_q[exp_q.size() - j] ? 2 : 1);
                    if (uni < 3 && uni == prev_uni) begin
                        exp_q[exp_q.size() - 3] = `CODE_TOP - exp_q[$];
                        exp_q[exp_q.size() - 2] = `CODE_MID;
                        exp_q[exp_q.size() - 1] = `CODE_MID;
                        uni = 3;
                    end
                    prev_uni = uni;
                end
            end
            if (nd8 == 8'hd8 && dat8 == 8'h27) begin
                align = 1'b1;
                idx = 0;
                prev_uni = 0;
            end
            prev = s;
            src.sym_q.push_back(s);
        end
    endtask
    // data bit chosen so the scrambled bit comes out as asked
    task want_sym(input o);
        add({2'b00, o ^ scr[5] ^ scr[6]});
    endtask
    task delimiter;
        begin
            r = $random(seed);
            for (k = 7; k >= 0; k = k - 1) add(((8'hd8 >> k) & 1) ? `SYM_NON_DATA : {2'b00, r[k]});
        end
    endtask
    // wait for the source to drain; three codes stay in the delay line
    task run_stream;
        begin
            for (k = 0; k < 3000 && src.sym_q.size() > 0; k = k + 1) @(posedge i_sys_clk);
            repeat (6) @(posedge i_sys_clk);
            check_code(exp_q.size(), 8'd3);
        end
    endtask
    task finish_test;
        begin
            $display("checked %0d fails %0d", checked, fails);
            if (fails == 0 && checked > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    // every pulse strobe carries the oldest expected code
    always @(negedge i_sys_clk) begin
        if (valid === 1'b1) begin
            ec = exp_q.pop_front();
            lv = pulse_for(ec, h1, h2);
            check_code(code, ec);
            check_level(level, lv);
            h2 = h1;
            h1 = lv;
        end
    end
    initial begin
        #400000;
        fails = fails + 1;
        finish_test;
    end
    initial begin
        model_reset;
        repeat (12) @(posedge i_sys_clk);
        @(negedge i_sys_clk) i_reset = 1'b0;
        repeat (2) add(`SYM_SILENCE);
        repeat (5) add(`SYM_PAD_IDLE);
        repeat (3) add(`SYM_SILENCE);
        delimiter;
        repeat (24) want_sym(1'b0);
        repeat (16) want_sym(1'b1);
        repeat (60) begin
            r = $random(seed);
            add(r[2:0]);
        end
        run_stream;
        @(negedge i_sys_clk) i_reset = 1'b1;
        repeat (2) @(posedge i_sys_clk);
        model_reset;
        @(negedge i_sys_clk) i_reset = 1'b0;
        slow = 1'b1;
        repeat (2) add(`SYM_SILENCE);
        // look-alike delimiter with a pad in a data slot must not align
        add(`SYM_NON_DATA);
        add(`SYM_NON_DATA);
        add(`SYM_PAD_IDLE);
        add(`SYM_NON_DATA);
        add(`SYM_NON_DATA);
        repeat (19) want_sym(1'b1);
        delimiter;
        repeat (16) want_sym(1'b1);
        repeat (80) begin
            r = $random(seed);
            add(r[3] ? {2'b00, r[0]} : r[2:0]);
        end
        run_stream;
        finish_test;
    end
endmodule
